// ==== clk_divider.sv ====
// File: oscillator divider producing board clock enables and levels
module clk_divider
(
    input  wire logic i_clk_sys,
    input  wire logic i_rst_n,
    output logic      o_clk8_true,
    output logic      o_clk8_inv,
    output logic      o_clk4_inv,
    output logic      o_clk8_rise_inv
);
    logic       toggle;
    logic       next_toggle;
    logic [3:0] count;
    logic [3:0] next_count;

    // ------------------------------------------------------------
    // Divider next state
    // ------------------------------------------------------------
    // Sys clock stands for the oscillator; levels, not real clocks
    always_comb
    begin
        next_toggle = ~toggle;
        next_count  = count + 4'h1;
        if (!i_rst_n)
        begin
            next_toggle = 1'b0;
            next_count  = cpu_support_pkg::DIV_RESET;
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        toggle <= next_toggle;
        count  <= next_count;
    end

    // Both phases of 8 MHz plus inverted 4 MHz
    assign o_clk8_true     = toggle;
    assign o_clk8_inv      = ~toggle;
    assign o_clk4_inv      = ~count[cpu_support_pkg::DIV_BIT_4MHZ];
    // Enable for the rising edge of the inverted clock
    assign o_clk8_rise_inv = toggle;
endmodule

// ==== cpu_bus_model.sv ====
// Partner: processor bus master running single strobed cycles
module cpu_bus_model
(
    input  wire logic   i_clk_sys,
    output logic [2:0]  o_func_code,
    output logic        o_as_n,
    output logic        o_grant_ack_n,
    output logic        o_rw,
    output logic [22:0] o_addr,
    output logic        o_smp
);
    // Idle: strobe high, bus owned by the processor
    initial {o_func_code, o_as_n, o_grant_ack_n, o_rw, o_addr, o_smp} = {3'h0, 3'h7, 24'h0};
    // One cycle; nothing is relied on from undefined PROM space
    task automatic run(input logic [2:0] f, input logic r, input logic [22:0] a, input logic g);
        @(posedge i_clk_sys);
        {o_func_code, o_rw, o_addr, o_grant_ack_n, o_as_n} <= {f, r, a, g, 1'b0};
        repeat (5) @(posedge i_clk_sys);
        o_smp <= 1'b1;
        @(posedge i_clk_sys);
        // Codes mean nothing off the strobe, so garble them
        {o_func_code, o_rw, o_addr, o_grant_ack_n, o_as_n, o_smp} <= {~f, ~r, ~a, 3'b110};
        repeat (4) @(posedge i_clk_sys);
    endtask
endmodule

// ==== cpu_cycle_decode_boot_map.sv ====
// File: top of processor-support logic: clocks, cycle decode, boot map
module cpu_cycle_decode_boot_map
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_n,
    input  wire logic [2:0]  i_func_code,
    input  wire logic        i_as_n,
    input  wire logic        i_cpu_grant_ack_n,
    input  wire logic        i_rw,
    input  wire logic [22:0] i_addr,
    input  wire logic [1:0]  i_rom_size,
    output logic             o_clk8_true,
    output logic             o_clk8_inv,
    output logic             o_clk4_inv,
    output logic             o_user_cycle_decode,
    output logic             o_supervisor_cycle_decode,
    output logic             o_intack_cycle_decode_n,
    output logic             o_iobus_intack_n,
    output logic             o_not_user_true,
    output logic             o_not_user_inv,
    output logic             o_boot,
    output logic             o_rom_chip_select_n
);
    cpu_support_pkg::cpu_cycle_t  s1;
    cpu_support_pkg::cpu_cycle_t  s2;
    cpu_support_pkg::fc_decode_t  dec;
    cpu_support_pkg::rom_size_t   rom_size;
    logic [1:0]  size_s1;
    logic [1:0]  size_s2;
    logic        clk8_t;
    logic        clk8_i;
    logic        clk4_i;
    logic        rise_en;
    logic        intack_dly_n;
    logic        next_intack_dly_n;
    logic        boot;
    logic        next_boot;
    logic        wr_seen;
    logic        next_wr_seen;
    logic        rom_cs_n;
    logic        next_rom_cs_n;
    logic        iobus_intack_n_n;
    logic        next_iobus_intack_n_n;
    logic        user_r;
    logic        super_r;
    logic        intack_r;
    logic        nu_t;
    logic        nu_i;
    logic        c8t;
    logic        c8i;
    logic        c4i;

    // Top of fitted PROM range
    function automatic logic [22:0] rom_top(input cpu_support_pkg::rom_size_t sz);
        unique case (sz)
            cpu_support_pkg::ROM_8K:  rom_top = cpu_support_pkg::ROM_TOP_8K;
            cpu_support_pkg::ROM_16K: rom_top = cpu_support_pkg::ROM_TOP_16K;
            default:                  rom_top = cpu_support_pkg::ROM_TOP_32K;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Processor runs asynchronously to us, so two flops first
    always_ff @(posedge i_clk_sys)
    begin
        s1      <= {i_func_code, i_as_n, i_cpu_grant_ack_n, i_rw, i_addr};
        s2      <= s1;
        size_s1 <= i_rom_size;
        size_s2 <= size_s1;
    end

    assign rom_size = cpu_support_pkg::rom_size_t'(size_s2);

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    clk_divider u_div
    (
        .i_clk_sys       (i_clk_sys),
        .i_rst_n         (i_rst_n),
        .o_clk8_true     (clk8_t),
        .o_clk8_inv      (clk8_i),
        .o_clk4_inv      (clk4_i),
        .o_clk8_rise_inv (rise_en)
    );

    fc_decoder u_fc
    (
        .i_as_n        (s2.as_n),
        .i_grant_ack_n (s2.grant_ack_n),
        .i_fc          (s2.fc),
        .o_dec         (dec)
    );

    // ------------------------------------------------------------
    // Interrupt acknowledge stretch
    // ------------------------------------------------------------
    // Delayed copy updates only on inverted-clock rising edge
    always_comb
    begin
        next_intack_dly_n = intack_dly_n;
        if (rise_en)
            next_intack_dly_n = dec.intack_cycle_decode_n;
        // Old copy, not the new one: a same-edge capture would kill the stretch
        next_iobus_intack_n_n = dec.intack_cycle_decode_n & intack_dly_n;
        if (!i_rst_n)
        begin
            next_intack_dly_n = 1'b1;
            next_iobus_intack_n_n       = 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        intack_dly_n <= next_intack_dly_n;
        iobus_intack_n_n       <= next_iobus_intack_n_n;
    end

    // ------------------------------------------------------------
    // Boot overlay and PROM select
    // ------------------------------------------------------------
    // Only reset sets the flag; writes can only clear it
    always_comb
    begin
        next_boot     = boot;
        next_wr_seen  = 1'b0;
        next_rom_cs_n = 1'b1;
        if (!s2.as_n && !s2.rw && s2.grant_ack_n)
            next_wr_seen = 1'b1;
        if (next_wr_seen && !wr_seen)
            next_boot = 1'b0;
        if (!s2.as_n && s2.grant_ack_n)
        begin
            if (boot)
                next_rom_cs_n = ~s2.rw;
            else if (s2.rw && dec.supervisor_cycle_decode &&
                     s2.addr[22:20] == cpu_support_pkg::ROM_BASE_NIB[2:0] &&
                     s2.addr >= cpu_support_pkg::ROM_BASE &&
                     s2.addr <= rom_top(rom_size))
                next_rom_cs_n = 1'b0;
        end
        if (!i_rst_n)
        begin
            next_boot     = cpu_support_pkg::BOOT_RESET;
            next_wr_seen  = 1'b0;
            next_rom_cs_n = 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        boot     <= next_boot;
        wr_seen  <= next_wr_seen;
        rom_cs_n <= next_rom_cs_n;
    end

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    // Every output leaves from a flop; costs one cycle of latency
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            user_r   <= 1'b0;
            super_r  <= 1'b0;
            intack_r <= 1'b1;
            nu_t     <= 1'b0;
            nu_i     <= 1'b1;
            c8t      <= 1'b0;
            c8i      <= 1'b1;
            c4i      <= 1'b1;
        end
        else
        begin
            user_r   <= dec.user_cycle_decode;
            super_r  <= dec.supervisor_cycle_decode;
            intack_r <= dec.intack_cycle_decode_n;
            nu_t     <= s2.fc[2];
            nu_i     <= ~s2.fc[2];
            c8t      <= clk8_t;
            c8i      <= clk8_i;
            c4i      <= clk4_i;
        end
    end

    assign o_clk8_true               = c8t;
    assign o_clk8_inv                = c8i;
    assign o_clk4_inv                = c4i;
    assign o_user_cycle_decode       = user_r;
    assign o_supervisor_cycle_decode = super_r;
    assign o_intack_cycle_decode_n   = intack_r;
    assign o_iobus_intack_n          = iobus_intack_n_n;
    assign o_not_user_true           = nu_t;
    assign o_not_user_inv            = nu_i;
    assign o_boot                    = boot;
    assign o_rom_chip_select_n       = rom_cs_n;
endmodule

// ==== cpu_support_pkg.sv ====
// Package: constants and carrier types for the processor-support block
package cpu_support_pkg;

    // ------------------------------------------------------------
    // Function codes and address map
    // ------------------------------------------------------------
    localparam logic [2:0]  FC_USER_DATA  = 3'h2;
    localparam logic [2:0]  FC_SUPER_DATA = 3'h5;
    localparam logic [2:0]  FC_SUPER_PROG = 3'h6;
    localparam logic [2:0]  FC_INTACK     = 3'h7;
    localparam logic [3:0]  ROM_BASE_NIB  = 4'h4;
    localparam logic [22:0] ROM_BASE      = 23'h400000;
    localparam logic [22:0] ROM_TOP_8K    = 23'h401FFF;
    localparam logic [22:0] ROM_TOP_16K   = 23'h403FFF;
    localparam logic [22:0] ROM_TOP_32K   = 23'h407FFF;

    // ------------------------------------------------------------
    // Reset values and counter positions
    // ------------------------------------------------------------
    localparam logic        BOOT_RESET    = 1'b1;
    localparam logic [3:0]  DIV_RESET     = 4'h0;
    localparam int          DIV_BIT_4MHZ  = 1;

    // PROM part size strap encoding
    typedef enum logic [1:0] {ROM_8K, ROM_16K, ROM_32K, ROM_RSVD} rom_size_t;

    // Processor bus cycle status, as sampled
    typedef struct packed {
        logic [2:0]  fc;
        logic        as_n;
        logic        grant_ack_n;
        logic        rw;
        logic [22:0] addr;
    } cpu_cycle_t;

    // Decode results
    typedef struct packed {
        logic user_cycle_decode;
        logic supervisor_cycle_decode;
        logic intack_cycle_decode_n;
    } fc_decode_t;

endpackage

// ==== cpu_support_sva.sv ====
// Checker: port properties of the processor-support block
module cpu_support_sva
(
    input wire logic       i_clk_sys,
    input wire logic       i_rst_n,
    input wire logic [2:0] i_func_code,
    input wire logic       i_as_n,
    input wire logic       i_cpu_grant_ack_n,
    input wire logic       i_rw,
    input wire logic       o_clk8_true,
    input wire logic       o_clk8_inv,
    input wire logic       o_clk4_inv,
    input wire logic       o_user_cycle_decode,
    input wire logic       o_supervisor_cycle_decode,
    input wire logic       o_intack_cycle_decode_n,
    input wire logic       o_iobus_intack_n,
    input wire logic       o_not_user_true,
    input wire logic       o_not_user_inv,
    input wire logic       o_boot,
    input wire logic       o_rom_chip_select_n
);
    logic [1:0] up_cnt;
    wire        rdy = (up_cnt == 2'h3);
    wire        cyc = !i_as_n && i_cpu_grant_ack_n;
    // Inputs lag three edges, so look back only once that many have passed
    always_ff @(posedge i_clk_sys) up_cnt <= !i_rst_n ? 2'h0 : up_cnt + 2'(!rdy);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    clk_div_a: assert property (rdy |-> o_clk8_inv != o_clk8_true
        && o_clk8_true != $past(o_clk8_true) && o_clk4_inv != $past(o_clk4_inv, 2))
        else $error("bad clocks");
    user_dec_a: assert property (rdy |->
        o_user_cycle_decode == $past(cyc && i_func_code == 3'h2, 3))
        else $error("bad user decode");
    super_dec_a: assert property (rdy |->
        o_supervisor_cycle_decode == $past(cyc && i_func_code inside {3'h5, 3'h6}, 3))
        else $error("bad supervisor decode");
    intack_dec_a: assert property (rdy |->
        o_intack_cycle_decode_n == !$past(cyc && i_func_code == 3'h7, 3))
        else $error("bad intack decode");
    intack_or_a: assert property (!o_intack_cycle_decode_n |-> !o_iobus_intack_n)
        else $error("bus intack missing");
    intack_stretch_a: assert property ($rose(o_intack_cycle_decode_n) |->
        !o_iobus_intack_n ##[1:2] o_iobus_intack_n)
        else $error("bus intack not stretched");
    mode_bit_a: assert property (rdy |-> o_not_user_inv != o_not_user_true
        && o_not_user_true == $past(i_func_code[2], 3))
        else $error("bad mode bit");
    boot_clear_a: assert property (rdy && $fell(o_boot) |-> $past(cyc && !i_rw, 3))
        else $error("boot cleared without write");
    cover property (!o_intack_cycle_decode_n);
    cover property ($fell(o_boot));
    cover property (!o_rom_chip_select_n && !o_boot);
endmodule

bind cpu_cycle_decode_boot_map cpu_support_sva chk_u (.i_clk_sys, .i_rst_n, .i_func_code,
    .i_as_n, .i_cpu_grant_ack_n, .i_rw, .o_clk8_true, .o_clk8_inv, .o_clk4_inv,
    .o_user_cycle_decode, .o_supervisor_cycle_decode, .o_intack_cycle_decode_n,
    .o_iobus_intack_n, .o_not_user_true, .o_not_user_inv, .o_boot, .o_rom_chip_select_n);

// ==== fc_decoder.sv ====
// File: function-code decoder, combinational
module fc_decoder
(
    input  wire logic                        i_as_n,
    input  wire logic                        i_grant_ack_n,
    input  wire logic [2:0]                  i_fc,
    output cpu_support_pkg::fc_decode_t      o_dec
);
    logic gate;

    // Strobe qualifies codes; a foreign master kills them
    always_comb
    begin
        gate = ~i_as_n & i_grant_ack_n;
        o_dec.user_cycle_decode = gate & (i_fc == cpu_support_pkg::FC_USER_DATA);
        o_dec.supervisor_cycle_decode = gate &
            ((i_fc == cpu_support_pkg::FC_SUPER_DATA) |
             (i_fc == cpu_support_pkg::FC_SUPER_PROG));
        o_dec.intack_cycle_decode_n = ~(gate & (i_fc == cpu_support_pkg::FC_INTACK));
    end
endmodule

// ==== tb.sv ====
// Testbench: decode and boot-map checks through bus cycles
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst_n, as_n, ga_n, rw, smp, boot_exp;
    logic        user, sup, ack_n, iob_n, nu_t, boot, cs_n;
    logic [1:0]  rom_size;
    logic [2:0]  fc;
    logic [22:0] addr;
    logic [6:0]  ev;
    logic [6:0]  q[$];
    int          error_cnt = 0;
    int          n_tests = 0;
    int          seed = 32'h32342df1;
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    cpu_cycle_decode_boot_map dut_u (.i_clk_sys(clk), .i_rst_n(rst_n), .i_func_code(fc),
        .i_as_n(as_n), .i_cpu_grant_ack_n(ga_n), .i_rw(rw), .i_addr(addr),
        .i_rom_size(rom_size), .o_clk8_true(), .o_clk8_inv(), .o_clk4_inv(),
        .o_user_cycle_decode(user), .o_supervisor_cycle_decode(sup),
        .o_intack_cycle_decode_n(ack_n), .o_iobus_intack_n(iob_n), .o_not_user_true(nu_t),
        .o_not_user_inv(), .o_boot(boot), .o_rom_chip_select_n(cs_n));
    cpu_bus_model cpu_u (.i_clk_sys(clk), .o_func_code(fc), .o_as_n(as_n),
        .o_grant_ack_n(ga_n), .o_rw(rw), .o_addr(addr), .o_smp(smp));
    function automatic logic [22:0] top_of(input logic [1:0] s);
        return (s == 2'h0) ? 23'h401FFF : (s == 2'h1) ? 23'h403FFF : 23'h407FFF;
    endfunction
    // Note what the cycle must show, then let the bus model run it
    task automatic cyc(input logic [2:0] f, input logic r, input logic [22:0] a, input logic g);
        logic sel;
        boot_exp = boot_exp && !(g && !r);
        sel = r && (boot_exp || (f inside {3'h5, 3'h6} && a >= 23'h400000
              && a <= top_of(rom_size)));
        q.push_back({g && f == 3'h2, g && f inside {3'h5, 3'h6}, !(g && f == 3'h7),
                     f[2], boot_exp, !sel, g});
        cpu_u.run(f, r, a, g);
    endtask
    // Each settled cycle retires the oldest note; no grant means no chip select
    always @(negedge clk)
    begin
        if (smp)
        begin
            ev = (q.size() > 0) ? q.pop_front() : 7'hX;
            n_tests++;
            if ({user, sup, ack_n, iob_n, nu_t, boot} !== {ev[6:4], ev[4:2]}
                || cs_n !== (ev[1] | !ev[0]))
            begin
                error_cnt++;
                $display("mismatch at %0t: got %b", $time, {user, sup, ack_n, iob_n, nu_t, boot, cs_n});
            end
        end
    end
    task automatic stop_test;
        $display("%0d checks, %0d mismatches", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0 && q.size() == 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        boot_exp = 1'b1;
    endtask
    // Boot overlay, relocation per part size, then a second power-on
    initial
    begin
        rst_n = 1'b0;
        rom_size = 2'h0;
        boot_exp = 1'b1;
        do_reset();
        for (int i = 0; i < 8; i++)
            cyc(3'(i), 1'b1, (i < 4) ? 23'(2 * i) : 23'($random(seed)), 1'b1);
        cyc(3'h7, 1'b1, 23'h400000, 1'b0);
        cyc(3'h5, 1'b1, 23'h000010, 1'b0);
        $display("boot test done");
        cyc(3'h5, 1'b0, 23'($random(seed)), 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            rom_size <= 2'(i);
            @(posedge clk);
            cyc(3'h6, 1'b1, top_of(2'(i)), 1'b1);
            cyc(3'h5, 1'b1, top_of(2'(i)) + 23'h1, 1'b1);
        end
        cyc(3'h2, 1'b1, 23'h400002, 1'b1);
        cyc(3'h1, 1'b0, 23'h400000, 1'b1);
        $display("relocation test done");
        do_reset();
        cyc(3'h2, 1'b1, 23'($random(seed)), 1'b1);
        $display("reset test done");
        stop_test();
    end
endmodule
